/* common/mas_pkg.sv */
// shared constants and types for the march address sequencer
package mas_pkg;
    localparam int ROW_BITS = 4;
    localparam int COL_BITS = 2;
    localparam int DATA_BITS = 8;
    localparam logic [7:0] RESET_DATA = 8'h00;
    // register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
    localparam logic [3:0] OFS_IRQ_CLR = 4'h3;
    localparam logic [3:0] OFS_IRQ_EN = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h5;
    localparam logic [3:0] OFS_ADDR = 4'h6;
    // control fields
    localparam int CTRL_START_BIT = 0;
    // interrupt bit positions
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_FAIL_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // one march phase per step, gray coded
    typedef enum logic [2:0] {
        MAS_IDLE = 3'h0,
        MAS_W0 = 3'h1,
        MAS_R0W1_UP = 3'h3,
        MAS_R1W0_UP = 3'h2,
        MAS_R0W1_DN = 3'h6,
        MAS_R1W0_DN = 3'h7,
        MAS_R0_DN = 3'h5,
        MAS_DONE = 3'h4
    } mas_phase_e;
    // cycle within a read-then-write operation
    typedef enum logic [1:0] {
        MAS_OP_READ = 2'h0,
        MAS_OP_CMP = 2'h1,
        MAS_OP_WRITE = 2'h3
    } mas_op_e;
endpackage

/* rtl/mas_segment.sv */
`timescale 1ns/100ps
// one address segment: up/down counter with wrap and hold-at-end
module mas_segment #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic load_min,
    input wire logic step,
    input wire logic down,
    input wire logic inhibit_wrap,
    // state
    output logic [WIDTH-1:0] value,
    output logic at_end
);
    localparam logic [WIDTH-1:0] MAX_VAL = '1;
    localparam logic [WIDTH-1:0] MIN_VAL = '0;
    logic [WIDTH-1:0] next_value;
    // refuse a segment with no bits at elaboration
    if (WIDTH < 1)
    begin : g_width_check
        $error("segment width must be at least one");
    end
    // terminal count depends on direction
    assign at_end = down ? (value == MIN_VAL) : (value == MAX_VAL);
    // wrap to the opposite extreme unless suppressed
    assign next_value = (at_end && inhibit_wrap) ? value :
                        (at_end && !down) ? MIN_VAL :
                        (at_end && down) ? MAX_VAL :
                        down ? value - WIDTH'(1) : value + WIDTH'(1);
    // counter register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            value <= '0;
        else if (load_min)
            value <= MIN_VAL;
        else if (step)
            value <= next_value;
    end
endmodule

/* rtl/mas_top.sv */
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps
// march c- self-test sequencer driving a synchronous ram
// Overview of operation
// - finish every cycle of an operation before the address moves
// - incrementing segment wraps from maximum to minimum unless inhibited
// - decrementing segment wraps from minimum to maximum unless inhibited
// - wrap suppression holds segments at the extreme for the next phase
// - advance phase only when both segments end and last operation completes
// - row counts every step; column steps only on row carry
// - background phase writes data register value at every address
// - read-then-write compares true data then writes inverted data
// - next pass expects inverted data and writes true data
// - six phases: w0 up, two rmw up, two rmw down, read down
// - background fixed ascending, final read fixed descending
// - setup loads write and expect data with all zeros
// - descending phase after held phase starts at memory top
// - straight data mapping, no per-sub-array inversion
// - descending phase ends when minimum address was operated on
module mas_top #(
    parameter int ROW_BITS = mas_pkg::ROW_BITS,
    parameter int COL_BITS = mas_pkg::COL_BITS,
    parameter int DATA_BITS = mas_pkg::DATA_BITS
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // memory under test
    output logic [ROW_BITS+COL_BITS-1:0] mem_addr,
    output logic [DATA_BITS-1:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    input wire logic [DATA_BITS-1:0] mem_rdata,
    // status
    output logic busy,
    output logic fail,
    output logic irq
);
    localparam int AW = ROW_BITS + COL_BITS;
    // geometry that the address and register paths cannot serve
    if (ROW_BITS < 1 || COL_BITS < 1 || DATA_BITS < 1 || DATA_BITS > 32 || AW > 16)
    begin : g_geometry_check
        $error("unsupported sequencer geometry");
    end

    // reset release through two flops
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // state
    mas_pkg::mas_phase_e phase;
    mas_pkg::mas_phase_e next_phase;
    mas_pkg::mas_op_e op;
    logic [DATA_BITS-1:0] data_reg;
    logic [DATA_BITS-1:0] expect_q;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [ROW_BITS-1:0] row_segment;
    logic [COL_BITS-1:0] column_segment;
    logic row_end;
    logic col_end;
    // read compare pipeline: the ram answers a cycle after its strobe
    logic rd_pend;
    logic [DATA_BITS-1:0] exp_pend;

    // register decode
    wire wr_ctrl = reg_wr && reg_addr == mas_pkg::OFS_CTRL;
    wire wr_clr = reg_wr && reg_addr == mas_pkg::OFS_IRQ_CLR;
    wire wr_en = reg_wr && reg_addr == mas_pkg::OFS_IRQ_EN;
    wire wr_data = reg_wr && reg_addr == mas_pkg::OFS_DATA;
    wire start = wr_ctrl && reg_wdata[mas_pkg::CTRL_START_BIT] && !busy;

    // phase attributes
    wire running = phase != mas_pkg::MAS_IDLE && phase != mas_pkg::MAS_DONE;
    wire dir_down = phase == mas_pkg::MAS_R0W1_DN || phase == mas_pkg::MAS_R1W0_DN
                    || phase == mas_pkg::MAS_R0_DN;
    wire is_write_only = phase == mas_pkg::MAS_W0;
    wire is_read_only = phase == mas_pkg::MAS_R0_DN;
    wire inv_expect = phase == mas_pkg::MAS_R1W0_UP
                      || phase == mas_pkg::MAS_R1W0_DN;
    wire inhibit = phase == mas_pkg::MAS_R1W0_UP;
    // last cycle of the current operation
    wire op_last = running && (is_write_only ? 1'b1 :
                   is_read_only ? op == mas_pkg::MAS_OP_CMP :
                   op == mas_pkg::MAS_OP_WRITE);
    wire addr_step = op_last;
    wire row_carry = row_end;
    wire col_step = addr_step && row_carry;
    wire last_addr = row_end && col_end;
    wire phase_done = op_last && last_addr;
    // compare a cycle after the read strobe, when the ram output stands
    wire mismatch = rd_pend && mem_rdata != exp_pend;

    // address segments of the primary address counter
    mas_segment #(.WIDTH(ROW_BITS)) u_row (
        .clk(clk),
        .rst_n(rst_n),
        .load_min(start),
        .step(addr_step),
        .down(dir_down),
        .inhibit_wrap(inhibit && last_addr),
        .value(row_segment),
        .at_end(row_end)
    );
    mas_segment #(.WIDTH(COL_BITS)) u_col (
        .clk(clk),
        .rst_n(rst_n),
        .load_min(start),
        .step(col_step),
        .down(dir_down),
        .inhibit_wrap(inhibit && last_addr),
        .value(column_segment),
        .at_end(col_end)
    );

    // march phase sequence
    always_comb
    begin
        next_phase = phase;
        case (phase)
            mas_pkg::MAS_IDLE: if (start) next_phase = mas_pkg::MAS_W0;
            mas_pkg::MAS_W0: if (phase_done) next_phase = mas_pkg::MAS_R0W1_UP;
            mas_pkg::MAS_R0W1_UP: if (phase_done) next_phase = mas_pkg::MAS_R1W0_UP;
            mas_pkg::MAS_R1W0_UP: if (phase_done) next_phase = mas_pkg::MAS_R0W1_DN;
            mas_pkg::MAS_R0W1_DN: if (phase_done) next_phase = mas_pkg::MAS_R1W0_DN;
            mas_pkg::MAS_R1W0_DN: if (phase_done) next_phase = mas_pkg::MAS_R0_DN;
            mas_pkg::MAS_R0_DN: if (phase_done) next_phase = mas_pkg::MAS_DONE;
            mas_pkg::MAS_DONE: if (start) next_phase = mas_pkg::MAS_W0;
            default: next_phase = mas_pkg::MAS_IDLE;
        endcase
    end

    // phase and operation cycle registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase <= mas_pkg::MAS_IDLE;
            op <= mas_pkg::MAS_OP_READ;
        end
        else
        begin
            phase <= next_phase;
            if (start || op_last)
                op <= mas_pkg::MAS_OP_READ;
            else if (running && op == mas_pkg::MAS_OP_READ)
                op <= mas_pkg::MAS_OP_CMP;
            else if (running && op == mas_pkg::MAS_OP_CMP)
                op <= mas_pkg::MAS_OP_WRITE;
        end
    end

    // memory drive: read strobe after op cycle 0, write strobe after cycle 1 (after cycle 0 in the background phase)
    wire [DATA_BITS-1:0] true_data = data_reg;
    wire [DATA_BITS-1:0] wr_val = inv_expect ? true_data : ~true_data;
    wire [DATA_BITS-1:0] next_wdata = is_write_only ? true_data : wr_val;
    wire next_we = running && (is_write_only ||
                   (!is_read_only && op == mas_pkg::MAS_OP_CMP));
    wire next_re = running && !is_write_only && op == mas_pkg::MAS_OP_READ;
    wire [AW-1:0] cur_addr = {column_segment, row_segment};
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_addr <= '0;
            mem_wdata <= '0;
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            expect_q <= '0;
            rd_pend <= 1'b0;
            exp_pend <= '0;
        end
        else
        begin
            mem_addr <= cur_addr;
            mem_wdata <= next_wdata;
            mem_we <= next_we;
            mem_re <= next_re;
            expect_q <= inv_expect ? ~true_data : true_data;
            rd_pend <= mem_re;                                           // ram data next cycle
            exp_pend <= expect_q;
        end
    end

    // data register, zero background at setup
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            data_reg <= DATA_BITS'(mas_pkg::RESET_DATA);
        else if (wr_data && !busy)
            data_reg <= reg_wdata[DATA_BITS-1:0];
    end

    // sticky fail and status
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fail <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            busy <= next_phase != mas_pkg::MAS_IDLE && next_phase != mas_pkg::MAS_DONE;
            if (start)
                fail <= 1'b0;
            else if (mismatch)
                fail <= 1'b1;
        end
    end

    // interrupt status: set wins over clear
    wire [1:0] irq_set = {mismatch, phase == mas_pkg::MAS_R0_DN && phase_done};
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat <= mas_pkg::IRQ_RESET;
            irq_en <= mas_pkg::IRQ_RESET;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~(wr_clr ? reg_wdata[1:0] : 2'h0)) | irq_set;
            if (wr_en)
                irq_en <= reg_wdata[1:0];
            irq <= |(irq_stat & irq_en);
        end
    end

    // read data mux, registered
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        case (reg_addr)
            mas_pkg::OFS_STATUS: rd_mux = {27'h0, phase, fail, busy};
            mas_pkg::OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat};
            mas_pkg::OFS_IRQ_EN: rd_mux = {30'h0, irq_en};
            mas_pkg::OFS_DATA: rd_mux = 32'(data_reg);
            mas_pkg::OFS_ADDR: rd_mux = 32'(cur_addr);
            default: rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end

    // assertions
    AST_ADDR_HOLD_MID_OP: assert property (@(posedge clk) disable iff (!rst_n)
        running && !op_last |=> $stable(cur_addr))
        else $error("address moved inside an operation");
    AST_UP_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
        addr_step && !dir_down && !inhibit && row_end |=> row_segment == '0)
        else $error("row did not wrap to minimum");
    AST_DN_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
        addr_step && dir_down && row_end && !col_end |=> row_segment == '1)
        else $error("row did not reload maximum");
    AST_HOLD_TOP: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_R1W0_UP && phase_done |=> cur_addr == '1)
        else $error("address did not hold at top");
    AST_ADVANCE: assert property (@(posedge clk) disable iff (!rst_n)
        running && !phase_done |=> phase == $past(phase))
        else $error("phase advanced early");
    AST_COL_CARRY: assert property (@(posedge clk) disable iff (!rst_n)
        addr_step && !row_end |=> $stable(column_segment))
        else $error("column stepped without carry");
    AST_W0_DATA: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_W0 |=> mem_we && mem_wdata == $past(data_reg))
        else $error("background write wrong");
    AST_RMW_INV: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_R0W1_UP && op == mas_pkg::MAS_OP_CMP
        |=> mem_we && mem_wdata == ~data_reg)
        else $error("inverted write missing");
    AST_FAIL_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
        mismatch && !start |=> fail ##1 (fail || $past(start)))
        else $error("fail flag not sticky");
    AST_RMW_TRUE: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_R1W0_UP && op == mas_pkg::MAS_OP_CMP
        |=> mem_we && mem_wdata == data_reg)
        else $error("true data write missing");
    AST_EXPECT_INV: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_R1W0_UP |=> expect_q == ~data_reg)
        else $error("expected data not inverted");
    AST_W0_NO_READ: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_W0 |=> !mem_re)
        else $error("read issued in background phase");
    AST_UP_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_W0 && addr_step && !last_addr
        |=> cur_addr == $past(cur_addr) + AW'(1))
        else $error("background phase not ascending");
    AST_DN_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_R0_DN && addr_step && !last_addr
        |=> cur_addr == $past(cur_addr) - AW'(1))
        else $error("final read phase not descending");
    AST_TOP_START: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_R0W1_DN && $past(phase) == mas_pkg::MAS_R1W0_UP
        |-> cur_addr == '1)
        else $error("descending phase did not start at top");
    AST_MIN_END: assert property (@(posedge clk) disable iff (!rst_n)
        phase_done && dir_down |-> cur_addr == '0)
        else $error("descending phase ended above minimum");
    AST_PHASE_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_R0W1_DN && phase_done |=> phase == mas_pkg::MAS_R1W0_DN)
        else $error("phase order broken");
    AST_READ_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_R0_DN |=> !mem_we)
        else $error("write issued in final read phase");
    AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !running && !start |=> $stable(cur_addr))
        else $error("address moved outside a run");

    // cover points for the main scenarios
    COV_DONE: cover property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_R0_DN ##1 phase == mas_pkg::MAS_DONE);
    COV_FAIL: cover property (@(posedge clk) disable iff (!rst_n) $rose(fail));
    COV_HOLD: cover property (@(posedge clk) disable iff (!rst_n)
        phase == mas_pkg::MAS_R1W0_UP ##1 phase == mas_pkg::MAS_R0W1_DN);
    COV_FAULT_DN: cover property (@(posedge clk) disable iff (!rst_n)
        mismatch && phase == mas_pkg::MAS_R0_DN);
endmodule

/* verif/mas_ram_model.sv */
`timescale 1ns/100ps
// synchronous ram model with one-cycle read latency and a fault hook
module mas_ram_model #(
    parameter int AW = 6,
    parameter int DW = 8
) (
    // clock
    input wire logic clk,
    // memory port
    input wire logic [AW-1:0] mem_addr,
    input wire logic [DW-1:0] mem_wdata,
    input wire logic mem_we,
    input wire logic mem_re,
    output logic [DW-1:0] mem_rdata,
    // fault injection: flip bit 0 on reads of one address
    input wire logic flip_en,
    input wire logic [AW-1:0] flip_addr
);
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] last = '0;
    logic valid = 1'b0;
    logic [DW-1:0] flip_mask;
    // cells start with a non-background pattern
    initial
    begin
        for (int i = 0; i < 2**AW; i++)
            mem[i] = 8'ha5;
    end
    assign flip_mask = (flip_en && mem_addr == flip_addr) ? DW'(1) : '0;
    // storage and read register
    always @(posedge clk)
    begin
        valid <= mem_re;
        if (mem_re)
            last <= mem[mem_addr] ^ flip_mask;
        if (mem_we)
            mem[mem_addr] <= mem_wdata;
    end
    // outside the data cycle the output changes, so a late sample cannot pass
    assign mem_rdata = valid ? last : ~last;
endmodule

/* verif/testbench.sv */
`timescale 1ns/100ps
// self-checking bench for the march address sequencer
module testbench;
    localparam int AW = mas_pkg::ROW_BITS + mas_pkg::COL_BITS;
    localparam int DEPTH = 1 << AW;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [AW-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic mem_we, mem_re, busy, fail, irq;
    logic flip_en = 1'b0;
    logic logging = 1'b0;
    logic [14:0] log_q [$];
    int n_mismatch = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    mas_top i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
        .busy(busy), .fail(fail), .irq(irq));
    mas_ram_model #(.AW(AW), .DW(8)) i_ram (.clk(clk), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
        .flip_en(flip_en), .flip_addr(AW'(5)));
    // record every memory access in issue order
    always @(posedge clk)
    begin
        if (logging && mem_we)
            log_q.push_back({1'b1, mem_addr, mem_wdata});
        if (logging && mem_re)
            log_q.push_back({1'b0, mem_addr, 8'h00});
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic reg_expect(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        reg_read(a, d);
        check(d, exp, what);
    endtask
    // start a run and confirm that it is under way
    task automatic start_run();
        reg_write(mas_pkg::OFS_CTRL, 32'h1 << mas_pkg::CTRL_START_BIT);
        repeat (3) @(posedge clk);
        #1;
        check(32'(busy), 32'h1, "busy after start");
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check(32'(busy), 32'h0, "run did not finish");
    endtask
    // compare the logged access stream with the six march phases
    task automatic check_log(input logic [7:0] d);
        logic [14:0] exp_q [$];
        logic [AW-1:0] a;
        logic [7:0] wd;
        for (int p = 0; p < 6; p++)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                a = (p < 3) ? AW'(i) : AW'(DEPTH - 1 - i);
                wd = (p == 1 || p == 3) ? ~d : d;
                if (p > 0)
                    exp_q.push_back({1'b0, a, 8'h00});
                if (p < 5)
                    exp_q.push_back({1'b1, a, wd});
            end
        end
        check(32'(log_q.size()), 32'(exp_q.size()), "access count");
        for (int k = 0; k < exp_q.size() && k < log_q.size(); k++)
            check(32'(log_q[k]), 32'(exp_q[k]), "access");
    endtask
    task automatic test_reset_regs();
        check(32'({busy, fail, irq}), 32'h0, "outputs after reset");
        reg_expect(mas_pkg::OFS_STATUS, 32'h0, "status after reset");
        reg_expect(mas_pkg::OFS_IRQ_STAT, 32'(mas_pkg::IRQ_RESET), "irq status reset");
        reg_expect(mas_pkg::OFS_DATA, 32'(mas_pkg::RESET_DATA), "background reset");
        reg_expect(4'hf, 32'h0, "unmapped read");
    endtask
    // clean run with a mixed background, interrupt masked and cleared
    task automatic test_clean_march(input logic [7:0] d);
        reg_write(mas_pkg::OFS_DATA, 32'(d));
        reg_write(mas_pkg::OFS_IRQ_EN, 32'h1 << mas_pkg::IRQ_DONE_BIT);
        log_q.delete();
        logging <= 1'b1;
        start_run();
        reg_write(mas_pkg::OFS_DATA, 32'h33);
        reg_write(mas_pkg::OFS_CTRL, 32'h1 << mas_pkg::CTRL_START_BIT); // ignored while busy
        wait_idle();
        logging <= 1'b0;
        check_log(d);
        check(32'(fail), 32'h0, "fail on clean memory");
        reg_expect(mas_pkg::OFS_STATUS, 32'(mas_pkg::MAS_DONE) << 2, "status at end");
        reg_expect(mas_pkg::OFS_DATA, 32'(d), "data write while busy");
        reg_expect(mas_pkg::OFS_ADDR, 32'(DEPTH - 1), "address after final wrap");
        check(32'(irq), 32'h1, "done interrupt");
        reg_write(mas_pkg::OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        check(32'(irq), 32'h0, "masked interrupt");
        reg_write(mas_pkg::OFS_IRQ_CLR, 32'h1 << mas_pkg::IRQ_DONE_BIT);
        reg_expect(mas_pkg::OFS_IRQ_STAT, 32'h0, "irq status cleared");
    endtask
    // one bad cell: sticky fail, mismatch interrupt, cleared by restart
    task automatic test_fault();
        flip_en <= 1'b1;
        reg_write(mas_pkg::OFS_IRQ_EN, 32'h1 << mas_pkg::IRQ_FAIL_BIT);
        start_run();
        wait_idle();
        check(32'(fail), 32'h1, "sticky fail");
        check(32'(irq), 32'h1, "mismatch interrupt");
        reg_expect(mas_pkg::OFS_IRQ_STAT, 32'h3, "irq status after fault");
        reg_write(mas_pkg::OFS_IRQ_CLR, 32'h3);
        repeat (2) @(posedge clk);
        #1;
        check(32'(irq), 32'h0, "interrupt after clear");
        flip_en <= 1'b0;
        start_run();
        check(32'(fail), 32'h0, "fail cleared by start");
        wait_idle();
        check(32'(fail), 32'h0, "fail after clean rerun");
    endtask
    task automatic results();
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        test_reset_regs();
        test_clean_march(8'h5a);
        test_fault();
        results();
    end
    // watchdog, about twenty times the expected run length
    initial
    begin
        #200000;
        n_mismatch++;
        results();
    end
endmodule
